// ---- dv/cvrf_engine_chk.sv ----
// Concurrent checks on the big-number engine ports.
module cvrf_engine_chk
    import cvrf_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic INSTR_VALID,
    input wire logic [WORD_W-1:0] INSTR_WORD,
    input wire logic INSTR_READY,
    input wire logic [BASE_W-1:0] CTL_BASE,
    input wire logic [DATA_W-1:0] CTL_MASK,
    input wire logic LOAD_REQ_VALID,
    input wire logic LOAD_REQ_READY,
    input wire logic [WORD_W-1:0] LOAD_REQ_ADDR,
    input wire logic LOAD_DATA_VALID,
    input wire logic LOAD_DATA_READY,
    input wire logic STORE_VALID,
    input wire logic STORE_READY,
    input wire logic [WORD_W-1:0] STORE_ADDR,
    input wire logic [WORD_W-1:0] RD_WORD,
    input wire logic BUSY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // An address lies in the masked word region above the base.
    function automatic logic in_region(input logic [31:0] a, input logic [23:0] b,
                                       input logic [12:0] m);
        return ((a - {b, 8'h00}) & ~{17'h0, m, 2'h0}) == 32'h0;
    endfunction
    sequence take_copy;
        INSTR_VALID && INSTR_READY && INSTR_WORD[OP_MSB:OP_LSB] == OP_COPY;
    endsequence
    sequence load_grant;
        LOAD_REQ_VALID && LOAD_REQ_READY;
    endsequence
    AST_BUSY_BLOCKS: assert property (BUSY |-> !INSTR_READY)
        else $error("instruction accepted while busy");
    AST_COPY_START: assert property (take_copy |=> BUSY && LOAD_REQ_VALID)
        else $error("copy did not start its first load");
    AST_LOAD_HOLD: assert property (LOAD_REQ_VALID && !LOAD_REQ_READY |=>
        LOAD_REQ_VALID && $stable(LOAD_REQ_ADDR)) else $error("load request dropped");
    AST_STORE_HOLD: assert property (STORE_VALID && !STORE_READY |=>
        STORE_VALID && $stable(STORE_ADDR)) else $error("store request dropped");
    AST_LOAD_STEP: assert property (load_grant |=> LOAD_DATA_READY && !STORE_VALID)
        else $error("load data not awaited after grant");
    AST_STORE_STEP: assert property (LOAD_DATA_VALID && LOAD_DATA_READY |=>
        STORE_VALID && !LOAD_REQ_VALID) else $error("store did not follow load data");
    AST_LOAD_REGION: assert property (LOAD_REQ_VALID |->
        in_region(LOAD_REQ_ADDR, CTL_BASE, CTL_MASK)) else $error("load outside region");
    AST_STORE_REGION: assert property (STORE_VALID |->
        in_region(STORE_ADDR, CTL_BASE, CTL_MASK)) else $error("store outside region");
    AST_IMAGE_GAPS: assert property (RD_WORD[31:29] == 3'h0 && RD_WORD[15:13] == 3'h0)
        else $error("register image has bits outside its fields");
    AST_RESET_CLEAR: assert property ($fell(RST) |-> RD_WORD == 32'h0 && !BUSY)
        else $error("state not cleared by reset");
endmodule
bind cvrf_engine cvrf_engine_chk u_chk (.*);

// ---- dv/cvrf_engine_tb.sv ----
// Self-checking bench for the big-number engine register file.
module cvrf_engine_tb;
    import cvrf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic INSTR_VALID = 1'b0;
    logic go = 1'b0;
    logic [31:0] INSTR_WORD = 32'h0;
    logic [23:0] CTL_BASE = 24'h0;
    logic [12:0] CTL_MASK = 13'h1fff;
    logic [3:0] RD_INDEX = 4'h0;
    logic INSTR_READY, LOAD_REQ_VALID, LOAD_REQ_READY, LOAD_DATA_VALID, LOAD_DATA_READY;
    logic STORE_VALID, STORE_READY, BUSY;
    logic [31:0] LOAD_REQ_ADDR, LOAD_DATA, STORE_ADDR, STORE_DATA, RD_WORD;
    logic [12:0] d[16] = '{default: 13'h0};
    logic [12:0] s[16] = '{default: 13'h0};
    logic [12:0] cp_rs, cp_rd;
    int seed = 97389;
    int n_fail, tests_run, cp_i, cp_n, k;
    cvrf_engine dut (.*);
    cvrf_mem_model mem (.clk(CLK_SYS), .rst(RST), .go(go), .req_valid(LOAD_REQ_VALID),
        .req_addr(LOAD_REQ_ADDR), .req_ready(LOAD_REQ_READY), .data_valid(LOAD_DATA_VALID),
        .data_ready(LOAD_DATA_READY), .data(LOAD_DATA), .store_valid(STORE_VALID),
        .store_ready(STORE_READY));
    always #10 CLK_SYS = ~CLK_SYS;
    // The memory side stalls at random.
    always @(posedge CLK_SYS) #1 go = 1'($random(seed));
    function automatic logic [12:0] wc(input logic [12:0] sz);
        return 13'(sz[12:5]) + 13'h1;
    endfunction
    function automatic logic [31:0] ea(input logic [12:0] off, input int i);
        return {CTL_BASE, 8'h00} + {17'h0, (off + 13'(i)) & CTL_MASK, 2'h0};
    endfunction
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Present one instruction, wait for it to be taken and update the expectation.
    task automatic issue(input logic [3:0] op, rd, rs, input logic [12:0] imm);
        INSTR_WORD = {op, rd, rs, 7'h00, imm};
        INSTR_VALID = 1'b1;
        for (k = 0; k < 9000 && INSTR_READY !== 1'b1; k++) @(posedge CLK_SYS) #1;
        @(posedge CLK_SYS) #1;
        case (op)
            OP_SET_DATA: d[rd] = imm;
            OP_SET_SIZE: s[rd] = imm;
            OP_ADD_DATA: d[rd] = d[rd] + d[rs];
            OP_ALLOC: begin
                d[15] = d[15] - wc(imm);
                d[rd] = d[15];
                s[rd] = imm;
            end
            OP_FREE: d[15] = d[15] + wc(s[rd]);
            OP_COPY: begin
                cp_rs = d[rs];
                cp_rd = d[rd];
                cp_i = 0;
                cp_n = int'(wc(s[rs]));
            end
            default: ;
        endcase
    endtask
    task automatic chkall();
        INSTR_VALID = 1'b0;
        for (int i = 0; i < 16; i++) begin
            RD_INDEX = 4'(i);
            @(posedge CLK_SYS) #1;
            cmp("register image", {3'h0, d[i], 3'h0, s[i]}, RD_WORD);
        end
    endtask
    task automatic copy(input logic [3:0] rd, rs);
        issue(OP_COPY, rd, rs, 13'h0);
        INSTR_VALID = 1'b0;
        for (k = 0; k < 9000 && BUSY !== 1'b0; k++) @(posedge CLK_SYS) #1;
        cmp("copy words", 32'(cp_n), 32'(cp_i));
    endtask
    // Follow each copied word at the memory ports.
    always @(posedge CLK_SYS) begin
        if (LOAD_REQ_VALID && LOAD_REQ_READY) begin
            cmp("load address", ea(cp_rs, cp_i), LOAD_REQ_ADDR);
        end
        if (STORE_VALID && STORE_READY) begin
            cmp("store address", ea(cp_rd, cp_i), STORE_ADDR);
            cmp("store data", ~ea(cp_rs, cp_i), STORE_DATA);
            cp_i++;
        end
    end
    // Main sequence.
    initial begin
        repeat (3) @(posedge CLK_SYS);
        #1 RST = 1'b0;
        chkall();
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            issue(OP_SET_DATA, 4'(i), 4'h0, 13'($random(seed)));
            issue(OP_SET_SIZE, 4'(i), 4'h0, 13'($random(seed)));
        end
        chkall();
        $display("test set done");
        for (int i = 0; i < 10; i++) begin
            issue(OP_ADD_DATA, 4'($random(seed)), 4'($random(seed)), 13'h0);
            issue(4'((i + 7) % 16), 4'(i), 4'(i), 13'h1fff);
        end
        chkall();
        $display("test add done");
        issue(OP_SET_DATA, 4'hf, 4'h0, 13'h1000);
        for (int i = 0; i < 4; i++) begin
            issue(OP_ALLOC, 4'(i), 4'h0,
                  i == 0 ? 13'h1fff : 13'($random(seed)));
        end
        chkall();
        for (int i = 3; i >= 0; i--) begin
            issue(OP_FREE, 4'(i), 4'h0, 13'h0);
        end
        chkall();
        $display("test stack done");
        for (int t = 0; t < 4; t++) begin
            CTL_BASE = 24'($random(seed));
            CTL_MASK = t == 0 ? 13'h00ff : 13'($random(seed));
            issue(OP_SET_DATA, 4'h1, 4'h0, t == 0 ? 13'h00fe : 13'($random(seed)));
            issue(OP_SET_SIZE, 4'h1, 4'h0, t == 1 ? 13'h1fff : 13'($random(seed)) & 13'h03ff);
            issue(OP_SET_DATA, 4'h2, 4'h0, 13'($random(seed)));
            copy(4'h2, 4'h1);
        end
        $display("test copy done");
        test_done();
    end
    // The run needs under 20000 cycles; this limit only cuts off a hang.
    initial begin
        #2000000;
        n_fail++;
        test_done();
    end
endmodule

// ---- dv/cvrf_mem_model.sv ----
// Load and store FIFO model that stands at the memory side of the engine.
module cvrf_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    output logic req_ready,
    output logic data_valid,
    input wire logic data_ready,
    output logic [31:0] data,
    input wire logic store_valid,
    output logic store_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pend;
    logic [31:0] addr_q;
    logic [31:0] churn;
    assign req_ready = go && !pend;
    assign data_valid = go && pend;
    assign store_ready = go;
    // The loaded word is the inverted address; idle data lines churn every cycle.
    assign data = pend ? ~addr_q : churn;
    // Track one outstanding load at a time.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pend <= 1'b0;
            addr_q <= 32'h0;
            churn <= 32'h0;
        end else begin
            churn <= churn + 32'h9e3779b9;
            if (req_valid && req_ready) begin
                pend <= 1'b1;
                addr_q <= req_addr;
            end else if (data_valid && data_ready) begin
                pend <= 1'b0;
            end
        end
    end
endmodule

// ---- src/cvrf_engine.sv ----
// Big-number engine register file, operand addressing and operand copy sequencer.
module cvrf_engine (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic INSTR_VALID,
    input wire logic [cvrf_pkg::WORD_W-1:0] INSTR_WORD,
    output logic INSTR_READY,
    input wire logic [cvrf_pkg::BASE_W-1:0] CTL_BASE,
    input wire logic [cvrf_pkg::DATA_W-1:0] CTL_MASK,
    output logic LOAD_REQ_VALID,
    input wire logic LOAD_REQ_READY,
    output logic [cvrf_pkg::WORD_W-1:0] LOAD_REQ_ADDR,
    input wire logic LOAD_DATA_VALID,
    output logic LOAD_DATA_READY,
    input wire logic [cvrf_pkg::WORD_W-1:0] LOAD_DATA,
    output logic STORE_VALID,
    input wire logic STORE_READY,
    output logic [cvrf_pkg::WORD_W-1:0] STORE_ADDR,
    output logic [cvrf_pkg::WORD_W-1:0] STORE_DATA,
    input wire logic [3:0] RD_INDEX,
    output logic [cvrf_pkg::WORD_W-1:0] RD_WORD,
    output logic BUSY
);
    import cvrf_pkg::*;

    // Instruction word layout used by the sequencer.
    // The opcode sits in the top nibble, then the destination index, then the source index.
    // The low thirteen bits carry the immediate, which is a data value or a size minus one.
    // Bits 19 down to 13 are not decoded and may hold anything.
    // Opcodes that the package does not name are taken and have no effect.
    // This keeps the instruction FIFO draining even when software sends a word we ignore.
    //
    // Timing seen from the instruction port.
    // A word is taken on the rising edge where valid and ready are both high.
    // Register field updates land on that same edge.
    // The readout port registers the image once more, so an update shows one edge later.
    // Only the copy opcode leaves the idle state; every other opcode takes one cycle.
    //
    // Timing seen from the memory side.
    // Each copied word runs load request, load data and store in strict order.
    // Every valid and its address hold steady until the matching ready is seen.
    // The next load address is worked out when the store is accepted, so no extra cycle is lost.
    //
    // Stack handling.
    // Allocation moves the stack pointer down by the rounded word count of the immediate size.
    // Freeing moves it up by the word count of the named register's size field.
    // When the destination of an allocation is the stack pointer itself, the destination
    // write is the later assignment and wins, so the pointer takes the new value once.
    // Nothing checks for pointer underflow; software must free in reverse order.
    //
    // Region bounding.
    // The mask is a plain AND on the word offset before it becomes a byte address.
    // Offsets therefore wrap inside the configured region instead of leaking past it.
    // The base field supplies address bits 31 down to 8, so the region is 256-byte aligned.
    // A base near the top of the address space wraps round on the final addition.

    // Words needed by an operand whose size field holds bits minus one.
    function automatic logic [CNT_W-1:0] words_of(input logic [SIZE_W-1:0] size_m1);
        words_of = {1'b0, size_m1[SIZE_W-1:5]} + 9'h001;
    endfunction

    // Byte address of a word offset inside the masked region.
    // The thirteen-bit word offset spans a 32 KB region at four bytes a word.
    function automatic logic [WORD_W-1:0] mem_addr(input logic [BASE_W-1:0] base,
                                                   input logic [DATA_W-1:0] mask,
                                                   input logic [DATA_W-1:0] off);
        logic [DATA_W-1:0] bounded;
        bounded = off & mask;
        mem_addr = {base, 8'h00} + {17'h00000, bounded, 2'b00};
    endfunction

    // Register file storage, one data and one size field per index.
    // The arrays are flip-flops so that any index can be read in the same cycle.
    // sixteen register pairs.
    logic [DATA_W-1:0] data_f [NUM_REGS];
    logic [SIZE_W-1:0] size_f [NUM_REGS];
    logic [DATA_W-1:0] next_data_f [NUM_REGS];
    logic [SIZE_W-1:0] next_size_f [NUM_REGS];
    cvrf_state_t state;
    cvrf_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] total;
    logic [CNT_W-1:0] next_total;
    logic [DATA_W-1:0] src_off;
    logic [DATA_W-1:0] next_src_off;
    logic [DATA_W-1:0] dst_off;
    logic [DATA_W-1:0] next_dst_off;
    logic [WORD_W-1:0] load_addr;
    logic [WORD_W-1:0] next_load_addr;
    logic [WORD_W-1:0] store_addr;
    logic [WORD_W-1:0] next_store_addr;
    logic [WORD_W-1:0] store_data;
    logic [WORD_W-1:0] next_store_data;
    logic [WORD_W-1:0] rd_word;
    logic [WORD_W-1:0] next_rd_word;

    // Instruction fields.
    logic [3:0] op;
    logic [3:0] rd;
    logic [3:0] rs;
    logic [DATA_W-1:0] imm;
    logic [CNT_W-1:0] alloc_words;
    logic [DATA_W-1:0] new_sp;

    // Decode of the instruction word at the head of the FIFO.
    always_comb begin
        op = INSTR_WORD[OP_MSB:OP_LSB];
        rd = INSTR_WORD[RD_MSB:RD_LSB];
        rs = INSTR_WORD[RS_MSB:RS_LSB];
        imm = INSTR_WORD[IMM_MSB:IMM_LSB];
        alloc_words = words_of(imm);
        new_sp = data_f[SP_INDEX] - {4'h0, alloc_words};
    end

    // Handshake outputs follow the sequencer state.
    always_comb begin
        INSTR_READY = (state == ST_IDLE);
        LOAD_REQ_VALID = (state == ST_LOAD_REQ);
        LOAD_DATA_READY = (state == ST_LOAD_WAIT);
        STORE_VALID = (state == ST_STORE);
        BUSY = (state != ST_IDLE);
    end

    // Next values of registers, sequencer and FIFO data.
    always_comb begin
        next_data_f = data_f;
        next_size_f = size_f;
        next_state = state;
        next_cnt = cnt;
        next_total = total;
        next_src_off = src_off;
        next_dst_off = dst_off;
        next_load_addr = load_addr;
        next_store_addr = store_addr;
        next_store_data = store_data;
        next_rd_word = '0;
        next_rd_word[DATA_MSB:DATA_LSB] = data_f[RD_INDEX];
        next_rd_word[SIZE_MSB:SIZE_LSB] = size_f[RD_INDEX];
        case (state)
            ST_IDLE: begin
                if (INSTR_VALID) begin
                    case (op)
                        OP_SET_DATA: begin
                            next_data_f[rd] = imm;
                        end
                        OP_SET_SIZE: begin
                            next_size_f[rd] = imm;
                        end
                        OP_ADD_DATA: begin
                            next_data_f[rd] = data_f[rd] + data_f[rs];
                        end
                        OP_ALLOC: begin
                            next_data_f[SP_INDEX] = new_sp;
                            next_data_f[rd] = new_sp;
                            next_size_f[rd] = imm;
                        end
                        OP_FREE: begin
                            next_data_f[SP_INDEX] = data_f[SP_INDEX]
                                + {4'h0, words_of(size_f[rd])};
                        end
                        OP_COPY: begin
                            next_total = words_of(size_f[rs]);
                            next_cnt = '0;
                            next_src_off = data_f[rs];
                            next_dst_off = data_f[rd];
                            next_load_addr = mem_addr(CTL_BASE, CTL_MASK, data_f[rs]);
                            next_state = ST_LOAD_REQ;
                        end
                        default: begin
                            next_state = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_LOAD_REQ: begin
                if (LOAD_REQ_READY) begin
                    next_state = ST_LOAD_WAIT;
                end
            end
            ST_LOAD_WAIT: begin
                if (LOAD_DATA_VALID) begin
                    next_store_data = LOAD_DATA;
                    next_store_addr = mem_addr(CTL_BASE, CTL_MASK,
                                               dst_off + {4'h0, cnt});
                    next_state = ST_STORE;
                end
            end
            ST_STORE: begin
                if (STORE_READY) begin
                    if (cnt + 9'h001 == total) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_cnt = cnt + 9'h001;
                        next_load_addr = mem_addr(CTL_BASE, CTL_MASK,
                                                  src_off + {4'h0, cnt + 9'h001});
                        next_state = ST_LOAD_REQ;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State registers.
    // Every register clears on reset, so the readout and the memory ports start at zero.
    // The sequencer holds idle while reset is high, so ready stays high but no instruction takes effect then.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                data_f[i] <= REG_RESET;
                size_f[i] <= REG_RESET;
            end
            state <= ST_IDLE;
            cnt <= '0;
            total <= '0;
            src_off <= '0;
            dst_off <= '0;
            load_addr <= '0;
            store_addr <= '0;
            store_data <= '0;
            rd_word <= '0;
        end else begin
            data_f <= next_data_f;
            size_f <= next_size_f;
            state <= next_state;
            cnt <= next_cnt;
            total <= next_total;
            src_off <= next_src_off;
            dst_off <= next_dst_off;
            load_addr <= next_load_addr;
            store_addr <= next_store_addr;
            store_data <= next_store_data;
            rd_word <= next_rd_word;
        end
    end

    // Registered data outputs.
    // Addresses and data come straight from flip-flops so they hold while a ready is awaited.
    assign LOAD_REQ_ADDR = load_addr;
    assign STORE_ADDR = store_addr;
    assign STORE_DATA = store_data;
    assign RD_WORD = rd_word;

endmodule

// ---- src/cvrf_pkg.sv ----
// Shared constants and types of the big-number engine register file.
package cvrf_pkg;

    // Register file shape.
    localparam int NUM_REGS = 16;
    localparam int DATA_W = 13;
    localparam int SIZE_W = 13;
    localparam int WORD_W = 32;
    localparam int CNT_W = 9;
    localparam logic [3:0] SP_INDEX = 4'hf;
    localparam logic [12:0] REG_RESET = 13'h0000;

    // Register word image field positions.
    localparam int DATA_MSB = 28;
    localparam int DATA_LSB = 16;
    localparam int SIZE_MSB = 12;
    localparam int SIZE_LSB = 0;

    // Instruction word field positions.
    localparam int OP_MSB = 31;
    localparam int OP_LSB = 28;
    localparam int RD_MSB = 27;
    localparam int RD_LSB = 24;
    localparam int RS_MSB = 23;
    localparam int RS_LSB = 20;
    localparam int IMM_MSB = 12;
    localparam int IMM_LSB = 0;

    // Engine control register base field and memory region.
    localparam int BASE_LSB = 8;
    localparam int BASE_W = 24;
    localparam int REGION_BYTES = 16384;
    localparam int WORD_BYTES = 4;
    localparam int REGION_WORDS = REGION_BYTES / WORD_BYTES;

    // Operation codes carried in the instruction word.
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_SET_DATA = 4'h1,
        OP_SET_SIZE = 4'h2,
        OP_ADD_DATA = 4'h3,
        OP_ALLOC = 4'h4,
        OP_FREE = 4'h5,
        OP_COPY = 4'h6
    } cvrf_op_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD_REQ,
        ST_LOAD_WAIT,
        ST_STORE
    } cvrf_state_t;

endpackage
